// >>> hdl/adccc_ctrl.v
// Function
// RQ1: one conversion starts by itself after reset
// RQ2: after conversion sleep while select high
// RQ3: result held unchanged while sleeping
// RQ4: select low in sleep enters data state
// RQ5: select high before first rise returns sleep
// RQ6: select high after first rise starts conversion
// RQ7: one output word per finished conversion (code pushes one per full 24-bit frame only, dropped if fifo full)
// RQ8: output changes on falling serial clock
// RQ9: input bits sampled on rising serial clock
// RQ10: 24 bits or select high starts conversion
// RQ11: clock mode chosen by pin timing only
// RQ12: first result after new setting valid
// RQ13: calibration inside cycle, timing unchanged
// RQ14: low supply holds block in reset
// RQ15: power-on reset about 4ms clears registers
// RQ16: reset defaults channel 0/1, 50/60, 1x, gain 1
// RQ17: first exchange after reset accepts new settings
// RQ18: distinct overrange and underrange codes
// RQ19: status outside data state, data inside
// RQ20: output shows done flag outside data state
// RQ21: select high floats output, ignores clock
// RQ22: word is flag, zero, sign, 17 bits, four zeros
// RQ23: clock driven unless host holds it low
// RQ24: new settings apply from next conversion
// RQ25: partial settings on abort are not applied
`timescale 1ns/100ps
`include "adccc_consts.vh"
module adccc_ctrl #(
   parameter POR_CYCLES  = `ADCCC_POR_CYCLES,
   parameter CONV_CYCLES = `ADCCC_CONV_CYCLES
) (
   input  wire        clk,
   input  wire        sys_rst,
   input  wire        supply_low,
   input  wire        chip_select_n,
   input  wire        serial_clk_in,
   output reg         serial_clk_out,
   output reg         serial_clk_oe,
   input  wire        serial_data_in,
   output reg         serial_data_out,
   output wire        serial_data_oe,
   input  wire [16:0] sample_magnitude,
   input  wire        sample_sign,
   input  wire        sample_over,
   input  wire        sample_under,
   output reg  [7:0]  active_config,
   output wire        converting,
   output wire        power_on_reset,
   output wire        result_valid,
   input  wire        result_ready,
   output wire [17:0] result_data
);
   // ----------------------------------------
   // states
   // ----------------------------------------
   localparam ST_POR  = 2'd0;
   localparam ST_CONV = 2'd1;
   localparam ST_SLP  = 2'd2;
   localparam ST_DATA = 2'd3;

   reg [1:0]  state;
   reg [31:0] por_cnt;
   reg [31:0] conv_cnt;
   reg [23:0] shift_word;
   reg [7:0]  cfg_shift;
   reg [4:0]  bit_cnt;
   reg        cfg_full;
   reg        ext_clk_mode;
   reg [7:0]  isck_div;
   reg [2:0]  cs_sync;
   reg [2:0]  sck_sync;
   reg        cs_n;
   reg        sck;
   reg        sck_prev;
   reg        cs_prev;
   reg [17:0] conv_word;
   wire       rise;
   wire       fall;
   wire       frame_sck;
   wire       fifo_ready;
   reg        push;

   // ----------------------------------------
   // pin sampling, change accepted when 2nd and 3rd agree
   // ----------------------------------------
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cs_sync  <= 3'h7;
         sck_sync <= 3'h0;
         cs_n     <= 1'b1;
         sck      <= 1'b0;
      end else begin
         cs_sync  <= {cs_sync[1:0], chip_select_n};
         sck_sync <= {sck_sync[1:0], serial_clk_in};
         if (cs_sync[2] == cs_sync[1]) begin
            cs_n <= cs_sync[2];
         end
         if (sck_sync[2] == sck_sync[1]) begin
            sck <= sck_sync[2];
         end
      end
   end

   // internal clock drives the pin only in master mode; edges seen from its own level
   assign frame_sck = ext_clk_mode ? sck : serial_clk_out; // RQ23
   assign rise      = frame_sck && !sck_prev && !cs_n;  // RQ21
   assign fall      = !frame_sck && sck_prev && !cs_n;  // RQ21
   assign power_on_reset = (state == ST_POR);
   assign converting     = (state == ST_CONV);
   assign serial_data_oe = !cs_n;                       // RQ21

   // ----------------------------------------
   // converter sequence
   // ----------------------------------------
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state           <= ST_POR;
         por_cnt         <= 32'h0;
         conv_cnt        <= 32'h0;
         shift_word      <= 24'h000000;
         cfg_shift       <= 8'h00;
         active_config   <= `ADCCC_CFG_DEFAULT;
         bit_cnt         <= 5'h00;
         cfg_full        <= 1'b0;
         ext_clk_mode    <= 1'b0;
         isck_div        <= 8'h00;
         serial_clk_out  <= 1'b0;
         serial_clk_oe   <= 1'b0;
         serial_data_out <= 1'b1;
         sck_prev        <= 1'b0;
         cs_prev         <= 1'b1;
         conv_word       <= 18'h00000;
         push            <= 1'b0;
      end else if (supply_low) begin
         state         <= ST_POR; // RQ14
         por_cnt         <= 32'h0;
         active_config   <= `ADCCC_CFG_DEFAULT;
         serial_clk_oe   <= 1'b0;
         serial_data_out <= 1'b1; // RQ14
         push            <= 1'b0;
      end else begin
         sck_prev <= frame_sck;
         cs_prev  <= cs_n;
         push     <= 1'b0;
         // clock mode decided by the pin level at each select fall
         if (cs_prev && !cs_n) begin
            ext_clk_mode <= !sck; // RQ11 RQ23
         end
         case (state)
            ST_POR: begin
               por_cnt <= por_cnt + 32'h1;
               if (por_cnt == POR_CYCLES - 1) begin // RQ15
                  ext_clk_mode  <= !sck; // RQ23
                  active_config <= `ADCCC_CFG_DEFAULT; // RQ16
                  conv_cnt      <= 32'h0;
                  state         <= ST_CONV; // RQ1
               end
            end
            ST_CONV: begin
               // calibration phases sit inside this fixed count
               conv_cnt <= conv_cnt + 32'h1; // RQ13
               if (conv_cnt == CONV_CYCLES - 1) begin
                  // over/under clamp to sign+msb codes
                  if (sample_over) begin
                     conv_word <= {1'b1, 1'b1, 16'h0000}; // RQ18
                  end else if (sample_under) begin
                     conv_word <= {1'b0, 1'b0, 16'hFFFF}; // RQ18
                  end else begin
                     conv_word <= {sample_sign, sample_magnitude}; // RQ12
                  end
                  state <= ST_SLP; // RQ2
               end
            end
            ST_SLP: begin
               // word rebuilt from conv_word every sleep cycle; stays put until read or replaced
               shift_word <= {1'b0, 1'b0, conv_word, 4'h0}; // RQ3 RQ22
               bit_cnt    <= 5'h00;
               cfg_full   <= 1'b0;
               if (!cs_n && cs_prev == 1'b0) begin
                  state <= ST_DATA; // RQ4
               end
            end
            ST_DATA: begin
               if (cs_n) begin
                  serial_clk_oe <= 1'b0;
                  if (bit_cnt != 5'h00) begin
                     conv_cnt <= 32'h0;
                     state    <= ST_CONV; // RQ6 RQ25
                  end else begin
                     state <= ST_SLP; // RQ5
                  end
               end else begin
                  if (!ext_clk_mode) begin
                     serial_clk_oe <= 1'b1;
                     isck_div      <= isck_div + 8'h01;
                     if (isck_div == `ADCCC_ISCK_HALF - 8'h01) begin
                        isck_div       <= 8'h00;
                        serial_clk_out <= !serial_clk_out;
                     end
                  end
                  if (rise) begin
                     // only the first bits of the frame carry settings
                     if (bit_cnt < `ADCCC_CFG_BITS) begin
                        cfg_shift <= {cfg_shift[6:0], serial_data_in}; // RQ9 RQ17
                     end
                     bit_cnt   <= bit_cnt + 5'h01;
                     if (bit_cnt == `ADCCC_CFG_BITS - 1) begin
                        cfg_full <= 1'b1;
                     end
                  end
                  if (fall) begin
                     shift_word <= {shift_word[22:0], 1'b0}; // RQ8
                     if (bit_cnt == `ADCCC_FRAME_BITS) begin
                        push           <= fifo_ready; // RQ7
                        serial_clk_oe  <= 1'b0;
                        serial_clk_out <= 1'b0;
                        conv_cnt       <= 32'h0;
                        state          <= ST_CONV; // RQ10
                     end
                  end
               end
            end
            default: begin
               state <= ST_POR;
            end
         endcase
         // settings latched only at conversion start
         if (state == ST_DATA && fall && bit_cnt == `ADCCC_FRAME_BITS && cfg_full) begin
            active_config <= cfg_shift; // RQ24
         end
         // output: status flag outside data state, word inside
         if (state == ST_DATA && !cs_n) begin
            serial_data_out <= (bit_cnt == `ADCCC_FRAME_BITS && fall) ? 1'b1 : shift_word[23];
         end else begin
            serial_data_out <= (state != ST_SLP); // RQ19 RQ20
         end
      end
   end

   // ----------------------------------------
   // completed words to the host side, one per full 24-bit frame, dropped if the fifo is full
   // ----------------------------------------
   adccc_fifo #(
      .WIDTH (18),
      .DEPTH (`ADCCC_FIFO_DEPTH),
      .AW    (5)
   ) u_fifo (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .in_valid  (push),
      .in_ready  (fifo_ready),
      .in_data   (conv_word),
      .out_valid (result_valid),
      .out_ready (result_ready),
      .out_data  (result_data)
   );
endmodule

// >>> common/adccc_consts.vh
`ifndef ADCCC_CONSTS_VH
`define ADCCC_CONSTS_VH
// ----------------------------------------
// frame layout
// ----------------------------------------
`define ADCCC_FRAME_BITS     5'd24
`define ADCCC_RESULT_BITS    17
`define ADCCC_CFG_BITS       8
// ----------------------------------------
// defaults loaded by power-on reset
// ----------------------------------------
`define ADCCC_CFG_DEFAULT    8'h00
// ----------------------------------------
// timing
// ----------------------------------------
`define ADCCC_CLK_MHZ        100
`define ADCCC_POR_US         4000
`define ADCCC_POR_CYCLES     (`ADCCC_POR_US * `ADCCC_CLK_MHZ)
`define ADCCC_CONV_CYCLES    2000
`define ADCCC_ISCK_HALF      8'd20
`define ADCCC_FIFO_DEPTH     32
`endif

// >>> hdl/adccc_fifo.v
`timescale 1ns/100ps
module adccc_fifo #(
   parameter WIDTH = 18,
   parameter DEPTH = 32,
   parameter AW    = 5
) (
   input  wire             clk,
   input  wire             sys_rst,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0]      wr_ptr;
   reg [AW:0]      rd_ptr;
   wire            full;
   wire            empty;

   assign full      = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   assign empty     = (wr_ptr == rd_ptr);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = mem[rd_ptr[AW-1:0]];

   always @(posedge clk) begin
      if (in_valid && !full) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr <= {(AW+1){1'b0}};
         rd_ptr <= {(AW+1){1'b0}};
      end else begin
         if (in_valid && !full) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (out_ready && !empty) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule

// >>> testbench/adccc_monitor.sv
`timescale 1ns/100ps
module adccc_monitor #(
   parameter POR_CYCLES  = 50,
   parameter CONV_CYCLES = 100
) (
   input wire clk,
   input wire sys_rst,
   input wire supply_low,
   input wire chip_select_n,
   input wire serial_clk_in,
   input wire serial_data_out,
   input wire serial_data_oe,
   input wire converting,
   input wire power_on_reset
);
   // ----------------------------
   // run lengths
   // ----------------------------
   // por count restarts while supply is low, since that stretches the hold
   int por_cnt;
   int conv_cnt;
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         por_cnt <= 0;
         conv_cnt <= 0;
      end else begin
         por_cnt <= (supply_low || !power_on_reset) ? 0 : por_cnt + 1;
         conv_cnt <= converting ? conv_cnt + 1 : 0;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   sequence s_wake;
      $fell(chip_select_n) && !converting && !power_on_reset ##1 !chip_select_n [*6];
   endsequence
   AST_CS_FLOAT: assert property (chip_select_n [*5] |-> !serial_data_oe)
      else $error("output driven while deselected");
   AST_WAKE_FLAG: assert property (s_wake |-> serial_data_oe && !serial_data_out)
      else $error("no ready flag after wake");
   AST_BUSY_FLAG: assert property ((!chip_select_n && converting) [*3] |-> serial_data_out)
      else $error("busy flag low during conversion");
   AST_SLEEP: assert property ((chip_select_n && !power_on_reset && !converting) [*8]
      |=> !converting)
      else $error("conversion left sleep with select high");
   AST_FIRST_CONV: assert property ($fell(power_on_reset) |-> ##[0:4] converting)
      else $error("no conversion after power-on reset");
   AST_POR_QUIET: assert property (power_on_reset [*2] |-> serial_data_out && !converting)
      else $error("activity during power-on reset");
   AST_POR_LEN: assert property ($fell(power_on_reset)
      |-> por_cnt inside {[POR_CYCLES - 4:POR_CYCLES + 6]})
      else $error("power-on reset length wrong");
   AST_CONV_LEN: assert property ($fell(converting) && !power_on_reset
      |-> conv_cnt inside {[CONV_CYCLES - 2:CONV_CYCLES + 4]})
      else $error("conversion length wrong");
   AST_SDO_STEADY: assert property ((!chip_select_n && serial_clk_in) [*5]
      |=> $stable(serial_data_out))
      else $error("data output moved while clock high");
endmodule
bind adccc_ctrl adccc_monitor #(.POR_CYCLES(POR_CYCLES), .CONV_CYCLES(CONV_CYCLES)) u_mon (
   .clk(clk), .sys_rst(sys_rst), .supply_low(supply_low), .chip_select_n(chip_select_n),
   .serial_clk_in(serial_clk_in), .serial_data_out(serial_data_out),
   .serial_data_oe(serial_data_oe), .converting(converting), .power_on_reset(power_on_reset)
);

// >>> testbench/adccc_host.sv
`timescale 1ns/100ps
module adccc_host (
   input  wire       clk,
   input  wire       sdo_pin,
   output reg        chip_select_n,
   output reg        sck_drive,
   output reg        serial_data_in
);
   // clock held low at every select fall keeps the device a clock follower
   initial begin
      chip_select_n = 1'b1;
      sck_drive = 1'b0;
      serial_data_in = 1'b0;
   end
   task frame(input [7:0] cfg, input integer nrise, output [23:0] word, output first);
      integer i;
      begin
         word = 24'h000000;
         @(negedge clk) chip_select_n = 1'b0;
         repeat (20) @(negedge clk);
         first = sdo_pin;
         for (i = 0; i < nrise; i = i + 1) begin
            serial_data_in = (i < 8) ? cfg[7 - i] : ~serial_data_in;
            repeat (7) @(negedge clk);
            sck_drive = 1'b1;
            word = {word[22:0], sdo_pin};
            repeat (6) @(negedge clk);
            sck_drive = 1'b0;
         end
         repeat (20) @(negedge clk);
         chip_select_n = 1'b1;
         serial_data_in = ~serial_data_in;
      end
   endtask
endmodule

// >>> testbench/adccc_ctrl_bench.sv
`timescale 1ns/100ps
module adccc_ctrl_bench;
   reg         clk = 1'b0;
   reg         sys_rst = 1'b1;
   reg         supply_low = 1'b0;
   reg  [16:0] sample_magnitude = 17'h00000;
   reg         sample_sign = 1'b1;
   reg         sample_over = 1'b0;
   reg         sample_under = 1'b0;
   reg         result_ready = 1'b1;
   wire        chip_select_n, sck_drive, serial_data_in, serial_clk_out, serial_clk_oe;
   wire        serial_data_out, serial_data_oe, converting, power_on_reset, result_valid;
   wire [7:0]  active_config;
   wire [17:0] result_data;
   wire        serial_clk_in = serial_clk_oe ? serial_clk_out : sck_drive;
   wire        sdo_pin = serial_data_oe ? serial_data_out : 1'bz;
   integer     errors = 0, checked = 0, nwords = 0, k;
   reg  [23:0] word;
   reg         first;
   reg  [17:0] prev;
   reg  [17:0] expq[$];
   always #5 clk = ~clk;
   always @(posedge clk) if (result_valid && result_ready) nwords <= nwords + 1;
   adccc_ctrl #(.POR_CYCLES(50), .CONV_CYCLES(100)) u_dut (
      .clk(clk), .sys_rst(sys_rst), .supply_low(supply_low), .chip_select_n(chip_select_n),
      .serial_clk_in(serial_clk_in), .serial_clk_out(serial_clk_out),
      .serial_clk_oe(serial_clk_oe), .serial_data_in(serial_data_in),
      .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
      .sample_magnitude(sample_magnitude), .sample_sign(sample_sign),
      .sample_over(sample_over), .sample_under(sample_under), .active_config(active_config),
      .converting(converting), .power_on_reset(power_on_reset), .result_valid(result_valid),
      .result_ready(result_ready), .result_data(result_data)
   );
   adccc_host u_host (.clk(clk), .sdo_pin(sdo_pin), .chip_select_n(chip_select_n),
      .sck_drive(sck_drive), .serial_data_in(serial_data_in));
   task cmp_w(input [23:0] got, input [23:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("BAD %0t word %h expected %h", $time, got, exp);
         end
      end
   endtask
   task cmp_b(input got, input exp);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
         end
      end
   endtask
   task tally_and_finish;
      begin
         $display("checks %0d mismatches %0d", checked, errors);
         if (errors == 0 && checked > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   task wait_idle;
      integer n;
      begin
         n = 0;
         while ((converting || power_on_reset) && n < 2000) begin
            @(negedge clk);
            n = n + 1;
         end
         if (n == 2000) begin
            errors = errors + 1;
            $display("BAD %0t wait ran out", $time);
            tally_and_finish;
         end
         @(negedge clk);
      end
   endtask
   initial begin
      repeat (4) @(negedge clk);
      sys_rst = 1'b0;
      cmp_b(power_on_reset, 1'b1);
      cmp_b(serial_data_oe, 1'b0);
      wait_idle;
      cmp_w({16'h0000, active_config}, 24'h000000);
      u_host.frame(8'hFF, 0, word, first);
      cmp_b(first, 1'b0);
      repeat (20) @(negedge clk);
      cmp_b(converting, 1'b0);
      u_host.frame(8'hA5, 24, word, first);
      cmp_w(word, 24'h200000);
      cmp_b(serial_clk_oe, 1'b0);
      cmp_b(serial_clk_out, 1'b0);
      u_host.frame(8'h00, 0, word, first);
      cmp_b(first, 1'b1);
      wait_idle;
      cmp_w({16'h0000, active_config}, 24'h0000A5);
      u_host.frame(8'h3C, 5, word, first);
      repeat (10) @(negedge clk);
      cmp_b(converting, 1'b1);
      wait_idle;
      cmp_w(word, 24'h000004);
      cmp_w({16'h0000, active_config}, 24'h0000A5);
      cmp_w(nwords[23:0], 24'h000001);
      result_ready = 1'b0;
      prev = 18'h20000;
      for (k = 0; k < 32; k = k + 1) begin
         u_host.frame(k[7:0], 24, word, first);
         cmp_w(word, {2'b00, prev, 4'h0});
         expq.push_back(prev);
         sample_over = (k == 0);
         sample_under = (k == 1);
         sample_sign = k[0];
         sample_magnitude = {k[7:0], ~k[8:0]};
         prev = (k == 0) ? 18'h30000 : (k == 1) ? 18'h0FFFF : {k[0], k[7:0], ~k[8:0]};
         wait_idle;
         cmp_w({16'h0000, active_config}, {16'h0000, k[7:0]});
      end
      for (k = 0; k < 32; k = k + 1) begin
         cmp_b(result_valid, 1'b1);
         cmp_w({6'h00, result_data}, {6'h00, expq.pop_front()});
         result_ready = 1'b1;
         @(negedge clk);
         result_ready = 1'b0;
         @(negedge clk);
      end
      cmp_b(result_valid, 1'b0);
      supply_low = 1'b1;
      repeat (10) @(negedge clk);
      cmp_b(power_on_reset, 1'b1);
      supply_low = 1'b0;
      wait_idle;
      cmp_w({16'h0000, active_config}, 24'h000000);
      tally_and_finish;
   end
endmodule
